// ---- pkg/strap_consts.vh ----
// constants for the reset strap sampler and clock ratio decoder
`ifndef STRAP_CONSTS_VH
`define STRAP_CONSTS_VH

// ---------------------------------------------------------------
// register map (word aligned byte addresses)
// ---------------------------------------------------------------
`define ADDR_PLAT_RATIO 4'h0
`define ADDR_CORE_RATIO 4'h4
`define ADDR_STRAP_RAW 4'h8
`define ADDR_STATUS 4'hc
`define ADDR_CONTROL 4'h0

// ---------------------------------------------------------------
// strap codes and decoded values
// ---------------------------------------------------------------
`define PR_CODE_16 4'h0
`define PR_CODE_2 4'h2
`define PR_CODE_3 4'h3
`define PR_CODE_4 4'h4
`define PR_CODE_5 4'h5
`define PR_CODE_6 4'h6
`define PR_CODE_8 4'h8
`define PR_CODE_9 4'h9
`define PR_CODE_10 4'ha
`define PR_CODE_12 4'hc
`define PR_MULT_16 5'h10
`define PR_MULT_2 5'h02
`define PR_MULT_3 5'h03
`define PR_MULT_4 5'h04
`define PR_MULT_5 5'h05
`define PR_MULT_6 5'h06
`define PR_MULT_8 5'h08
`define PR_MULT_9 5'h09
`define PR_MULT_10 5'h0a
`define PR_MULT_12 5'h0c
// core ratio in half steps: numerator over 2
`define CR_CODE_2_1 2'h0
`define CR_CODE_5_2 2'h1
`define CR_CODE_3_1 2'h2
`define CR_CODE_7_2 2'h3
`define CR_HALF_2_1 3'h4
`define CR_HALF_5_2 3'h5
`define CR_HALF_3_1 3'h6
`define CR_HALF_7_2 3'h7

// ---------------------------------------------------------------
// reset values and field positions
// ---------------------------------------------------------------
`define RST_MULT 5'h00
`define RST_HALF 3'h0
`define RST_CODE4 4'h0
`define RST_CODE2 2'h0
`define RST_WORD 32'h0000_0000
`define ST_LATCHED 0
`define ST_RESERVED 1
`define ST_PCI64 2
`define RAW_PLAT_LSB 0
`define RAW_CORE_LSB 4

`endif

// ---- src/clock_ratio_strap_decoder.v ----
// reset strap sampler: platform and core clock ratios, pci width, pin control
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
// Functional notes
// - the platform-to-system clock multiplier comes from the four platform ratio straps sampled at power-up.
// - codes 0,2,3,4,5,6,8,9,10,12 give 16,2,3,4,5,6,8,9,10,12; the rest are reserved.
// - the core ratio code is address latch strap then general line 2 strap, sampled at power-up.
// - core codes 00,01,10,11 give core to platform ratios 2:1, 5:2, 3:1 and 7:2.
// - one platform clock equal to the core complex bus clock drives the cache, memory data rate and bus.
// - the memory bus clock runs at half the platform clock so the memory data rate equals it.
// - weak pull-ups on configuration pins are on only during reset; the code keeps them on until straps_latched sets, one cycle after release.
// - configuration pins are inputs during reset and functional outputs afterwards.
// - designated outputs are driven actively throughout reset, never released.
// - the pci 64-bit request line sampled low during reset selects 64-bit operation, else 32-bit.

`include "strap_consts.vh"

module clock_ratio_strap_decoder #(
   parameter MIN_PLAT_MHZ = 200,
   parameter SYS_MHZ = 100
) (
   input wire clk,
   input wire rst,
   input wire [3:0] platform_ratio_straps_in,
   input wire address_latch_strap_in,
   input wire general_line2_strap_in,
   input wire pci_req64_in,
   input wire [3:0] platform_ratio_straps_func,
   input wire address_latch_strap_func,
   input wire general_line2_strap_func,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   output reg [1:0] avs_response,
   output wire [3:0] platform_ratio_straps_out,
   output wire [3:0] platform_ratio_straps_oe,
   output wire address_latch_strap_out,
   output wire address_latch_strap_oe,
   output wire general_line2_strap_out,
   output wire general_line2_strap_oe,
   output wire strap_pullup_en,
   output wire reset_driven_oe,
   output wire [4:0] platform_mult,
   output wire [2:0] core_ratio_half,
   output wire ratio_reserved,
   output wire pci_64bit,
   output wire straps_latched,
   output wire platform_clk_sel,
   output wire [5:0] memory_clk_div
);

   // ---------------------------------------------------------------
   // pin synchronisers: straps come from off-chip
   // ---------------------------------------------------------------
   reg [6:0] sync1_q;
   reg [6:0] sync2_q;
   always @(posedge clk) begin
      sync1_q <= {pci_req64_in, general_line2_strap_in, address_latch_strap_in, platform_ratio_straps_in};
      sync2_q <= sync1_q;
   end

   // ---------------------------------------------------------------
   // capture at reset release
   // ---------------------------------------------------------------
   // the flop chain adds two cycles, so sampling continues while rst is high and
   // the last value seen before release is frozen; later pin motion is ignored
   reg [3:0] plat_code_q;
   reg [1:0] core_code_q;
   reg req64_n_q;
   reg latched_q;
   always @(posedge clk) begin
      if (rst) begin
         plat_code_q <= sync2_q[3:0];
         core_code_q <= {sync2_q[4], sync2_q[5]};
         req64_n_q <= sync2_q[6];
         latched_q <= 1'b0;
      end else begin
         latched_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // decoders
   // ---------------------------------------------------------------
   reg [4:0] mult_d;
   reg rsv_d;
   always @* begin
      rsv_d = 1'b0;
      case (plat_code_q)
         `PR_CODE_16: mult_d = `PR_MULT_16;
         `PR_CODE_2: mult_d = `PR_MULT_2;
         `PR_CODE_3: mult_d = `PR_MULT_3;
         `PR_CODE_4: mult_d = `PR_MULT_4;
         `PR_CODE_5: mult_d = `PR_MULT_5;
         `PR_CODE_6: mult_d = `PR_MULT_6;
         `PR_CODE_8: mult_d = `PR_MULT_8;
         `PR_CODE_9: mult_d = `PR_MULT_9;
         `PR_CODE_10: mult_d = `PR_MULT_10;
         `PR_CODE_12: mult_d = `PR_MULT_12;
         default: begin
            // no default ratio exists; reserved codes report zero and flag it
            mult_d = `RST_MULT;
            rsv_d = 1'b1;
         end
      endcase
   end

   reg [2:0] half_d;
   always @* begin
      case (core_code_q)
         `CR_CODE_2_1: half_d = `CR_HALF_2_1;
         `CR_CODE_5_2: half_d = `CR_HALF_5_2;
         `CR_CODE_3_1: half_d = `CR_HALF_3_1;
         `CR_CODE_7_2: half_d = `CR_HALF_7_2;
         default: half_d = `RST_HALF;
      endcase
   end

   // outputs registered, loaded as straps_latched sets and held steady after
   reg [4:0] mult_q;
   reg [2:0] half_q;
   reg rsv_q;
   reg pci64_q;
   reg slow_q;
   always @(posedge clk) begin
      if (rst) begin
         mult_q <= `RST_MULT;
         half_q <= `RST_HALF;
         rsv_q <= 1'b0;
         pci64_q <= 1'b0;
         slow_q <= 1'b0;
      end else if (!latched_q) begin
         mult_q <= mult_d;
         half_q <= half_d;
         rsv_q <= rsv_d;
         pci64_q <= ~req64_n_q;
         // board duty only; flagged for software, not enforced
         // sixteen bits keep 16 x sys from wrapping before the compare
         slow_q <= ({11'h000, mult_d} * SYS_MHZ[15:0]) < MIN_PLAT_MHZ[15:0];
      end
   end

   assign platform_mult = mult_q;
   assign core_ratio_half = half_q;
   assign ratio_reserved = rsv_q;
   assign pci_64bit = pci64_q;
   assign straps_latched = latched_q;
   // one platform clock feeds cache, memory data path and core complex bus
   assign platform_clk_sel = latched_q;
   // memory clock is twice the platform period: divide by 2x multiplier of sys
   assign memory_clk_div = {mult_q, 1'b0};

   // ---------------------------------------------------------------
   // pin control
   // ---------------------------------------------------------------
   assign strap_pullup_en = rst | ~latched_q;
   // rst gates the drivers at once: latched_q only clears one edge into reset
   wire pins_out_en;
   assign pins_out_en = latched_q & ~rst;
   assign platform_ratio_straps_oe = {4{pins_out_en}};
   assign address_latch_strap_oe = pins_out_en;
   assign general_line2_strap_oe = pins_out_en;
   assign platform_ratio_straps_out = pins_out_en ? platform_ratio_straps_func : 4'h0;
   assign address_latch_strap_out = pins_out_en & address_latch_strap_func;
   assign general_line2_strap_out = pins_out_en & general_line2_strap_func;
   assign reset_driven_oe = 1'b1;

   // ---------------------------------------------------------------
   // avalon slave: status reads plus one writable control bit at address 0, zero wait states
   // ---------------------------------------------------------------
   reg diag_hold_q;
   assign avs_waitrequest = 1'b0;
   always @(posedge clk) begin
      if (rst) begin
         diag_hold_q <= 1'b0;
      end else if (avs_write && avs_address == `ADDR_CONTROL && avs_byteenable[0]) begin
         diag_hold_q <= avs_writedata[0];
      end
   end

   reg [31:0] rd_d;
   reg [1:0] resp_d;
   always @* begin
      rd_d = `RST_WORD;
      resp_d = 2'h0;
      case (avs_address)
         `ADDR_PLAT_RATIO: rd_d = {26'h0, diag_hold_q, mult_q};
         `ADDR_CORE_RATIO: rd_d = {29'h0, half_q};
         `ADDR_STRAP_RAW: rd_d = {25'h0, req64_n_q, core_code_q, plat_code_q};
         `ADDR_STATUS: rd_d = {28'h0, slow_q, pci64_q, rsv_q, latched_q};
         default: resp_d = 2'h2;
      endcase
   end

   // read data valid in the same cycle as the request since waitrequest is low
   always @* begin
      avs_readdata = avs_read ? rd_d : `RST_WORD;
      avs_response = (avs_read | avs_write) ? resp_d : 2'h0;
   end

endmodule // clock_ratio_strap_decoder

// ---- bench/strap_board.sv ----
// board strap resistors and reset logic model
`timescale 1ns/1ps
module strap_board(
   input wire rst,
   input wire [3:0] code,
   input wire [1:0] core,
   input wire want64,
   output wire [3:0] plat,
   output wire ale,
   output wire gl2,
   output wire req64_n
);
   // resistors hold the code whenever the device lets go of the pins
   assign plat = code;
   assign {ale, gl2} = core;
   // driven low only in reset, pull-up afterwards
   assign req64_n = !(rst && want64);
endmodule // strap_board

// ---- bench/clock_ratio_strap_decoder_assertions.sv ----
// assertion checker for the strap decoder ports
`timescale 1ns/1ps
module clock_ratio_strap_decoder_assertions(
   input wire clk, input wire rst, input wire strap_pullup_en, input wire reset_driven_oe,
   input wire [3:0] platform_ratio_straps_oe, input wire address_latch_strap_oe, input wire [4:0] platform_mult,
   input wire [2:0] core_ratio_half, input wire ratio_reserved, input wire pci_64bit, input wire straps_latched,
   input wire platform_clk_sel, input wire [5:0] memory_clk_div
);
   default clocking @(posedge clk); endclocking
   a_pullup_reset: assert property (rst |-> strap_pullup_en) else $error("pullup off in reset");
   a_pins_input: assert property (rst |-> platform_ratio_straps_oe == 4'h0 && !address_latch_strap_oe)
      else $error("strap pin driven in reset");
   a_drive_reset: assert property (reset_driven_oe) else $error("output released");
   a_latch_next: assert property (disable iff (rst) $fell(rst) |=> straps_latched) else $error("no latch");
   a_ratio_hold: assert property (disable iff (rst) $past(straps_latched) |->
      $stable({platform_mult, core_ratio_half, pci_64bit})) else $error("ratio changed");
   a_mem_half: assert property (straps_latched |-> memory_clk_div == {platform_mult, 1'b0})
      else $error("memory divider wrong");
   a_rsv_zero: assert property (straps_latched |-> ratio_reserved == (platform_mult == 5'h00))
      else $error("reserved flag wrong");
   a_clk_sel: assert property (platform_clk_sel == straps_latched) else $error("clock select wrong");
   c_rsv: cover property (ratio_reserved);
   c_pci64: cover property (pci_64bit);
   c_core72: cover property (straps_latched && core_ratio_half == 3'h7);
endmodule // clock_ratio_strap_decoder_assertions
bind clock_ratio_strap_decoder clock_ratio_strap_decoder_assertions u_chk(.clk(clk), .rst(rst),
   .strap_pullup_en(strap_pullup_en), .reset_driven_oe(reset_driven_oe),
   .platform_ratio_straps_oe(platform_ratio_straps_oe), .address_latch_strap_oe(address_latch_strap_oe),
   .platform_mult(platform_mult), .core_ratio_half(core_ratio_half), .ratio_reserved(ratio_reserved),
   .pci_64bit(pci_64bit), .straps_latched(straps_latched), .platform_clk_sel(platform_clk_sel),
   .memory_clk_div(memory_clk_div));

// ---- bench/clock_ratio_strap_decoder_tb_top.sv ----
// testbench for the strap decoder
`timescale 1ns/1ps
module clock_ratio_strap_decoder_tb_top;
   logic clk = 0, rst = 1, rd = 0, wr = 0, w64 = 0, af = 0, gf = 0;
   logic [3:0] addr = 0, code = 0, be = 4'hf, pf = 0;
   logic [1:0] core = 0;
   logic [31:0] wd = 0;
   wire [3:0] pout, poe, bp;
   wire [1:0] resp;
   wire [31:0] rdata;
   wire ao, aoe, go, goe, ale, gl2, rq, pu, wq;
   int mismatches = 0, n_tests = 0;
   logic [33:0] q[$];
   // pin level: device drives when enabled, resistors otherwise
   wire [3:0] pw = (poe & pout) | (~poe & bp);
   strap_board u_strap_board(.rst(rst), .code(code), .core(core), .want64(w64), .plat(bp), .ale(ale), .gl2(gl2),
      .req64_n(rq));
   clock_ratio_strap_decoder u_clock_ratio_strap_decoder(.clk(clk), .rst(rst), .platform_ratio_straps_in(pw),
      .address_latch_strap_in(aoe ? ao : ale), .general_line2_strap_in(goe ? go : gl2), .pci_req64_in(rq),
      .platform_ratio_straps_func(pf), .address_latch_strap_func(af), .general_line2_strap_func(gf),
      .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
      .avs_readdata(rdata), .avs_waitrequest(wq), .avs_response(resp), .platform_ratio_straps_out(pout),
      .platform_ratio_straps_oe(poe), .address_latch_strap_out(ao), .address_latch_strap_oe(aoe),
      .general_line2_strap_out(go), .general_line2_strap_oe(goe), .strap_pullup_en(pu), .reset_driven_oe(),
      .platform_mult(), .core_ratio_half(), .ratio_reserved(), .pci_64bit(), .straps_latched(),
      .platform_clk_sel(), .memory_clk_div());
   initial forever #5 clk = ~clk;
   task check(input string nm, input logic [33:0] s, input logic [33:0] e);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [33:0] e);
      int k;
      @(posedge clk);
      rd <= !w; wr <= w; addr <= a; wd <= d;
      if (!w) q.push_back(e);
      for (k = 0; k < 50 && (k == 0 || wq !== 1'b0); k++) @(posedge clk);
      if (k == 50) begin mismatches++; summarize(); end
      rd <= 0; wr <= 0;
   endtask
   // read results pair with the oldest note at the accepting edge
   always @(posedge clk) if (rd && wq === 1'b0) check("read", {resp, rdata}, q.pop_front());
   function automatic logic [4:0] dec(input logic [3:0] c);
      if (c == 4'h0) return 5'h10;
      return (c inside {4'h1, 4'h7, 4'hb, 4'hd, 4'he, 4'hf}) ? 5'h00 : {1'b0, c};
   endfunction
   initial begin
      logic [4:0] m;
      void'($urandom(92));
      repeat (12) @(posedge clk);
      for (int i = 0; i < 16; i++) begin
         rst <= 1; code <= i; core <= i[1:0] ^ i[3:2]; w64 <= $urandom % 2;
         pf <= $urandom; af <= $urandom; gf <= $urandom;
         repeat (4) @(posedge clk);
         rst <= 0;
         repeat (2) @(posedge clk);
         m = dec(code);
         bus(0, 4'h0, 0, {29'h0, m});
         bus(0, 4'h4, 0, {31'h0, 3'h4 + core});
         bus(0, 4'h8, 0, {27'h0, !w64, core, code});
         bus(0, 4'hc, 0, {30'h0, m < 5'h02, w64, m == 5'h00, 1'b1});
         check("strap out", {aoe, goe, poe, ao, go, pout}, {1'b1, 1'b1, 4'hf, af, gf, pf});
         check("pullup", pu, 0);
         $display("test %0d done", i);
      end
      bus(1, 4'h0, 32'h1, 0);
      bus(0, 4'h0, 0, 34'h20);
      bus(1, 4'h4, 32'hffff_ffff, 0);
      bus(0, 4'h4, 0, 34'h4);
      bus(0, 4'h6, 0, {2'h2, 32'h0});
      @(posedge clk);
      check("queue", q.size(), 0);
      $display("register test done");
      summarize();
   end
endmodule // clock_ratio_strap_decoder_tb_top
